// ---- design/tcs_pkg.sv ----
// Constants and types for the timer channel status and control block.
// Assumes a byte-wide register port with byte addresses on a 4-bit bus.
package tcs_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] TCS_ADDR_CSC = 4'h0;
  localparam logic [3:0] TCS_ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] TCS_ADDR_IRQ_MASK = 4'h8;

  // ==========================================================
  // Field positions of channel_status_control
  localparam int TCS_FLAG_BIT = 7;
  localparam int TCS_IE_BIT = 6;
  localparam int TCS_MSH_BIT = 5;
  localparam int TCS_MSL_BIT = 4;
  localparam int TCS_ELSH_BIT = 3;
  localparam int TCS_ELSL_BIT = 2;

  // Field positions of the interrupt status and mask registers.
  localparam int TCS_IRQ_EVENT_BIT = 0;
  localparam int TCS_IRQ_OVERRUN_BIT = 1;
  localparam int TCS_IRQ_W = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] TCS_RDATA_RESET = 8'h00;
  localparam logic [1:0] TCS_IRQ_RESET = 2'h0;

  // ==========================================================
  // Timing: pin input stages and the settle time before capture mode.
  localparam int TCS_SYNC_STAGES = 3;
  localparam int TCS_PIN_SETTLE_CLKS = 2;

  // Edge/level select codes.
  localparam logic [1:0] TCS_ELS_OFF = 2'h0;
  localparam logic [1:0] TCS_ELS_CLEAR = 2'h2;

  // Channel operating mode.
  typedef enum logic [1:0] {
    TCS_MODE_CAPTURE = 2'b00,
    TCS_MODE_COMPARE = 2'b01,
    TCS_MODE_EDGE_PWM = 2'b10,
    TCS_MODE_CENTRE_PWM = 2'b11
  } tcs_mode_e;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tcs_bus_req_s;

  // Edge report from the pin input stage.
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tcs_pin_evt_s;

endpackage

// ---- design/tcs_pin_sync.sv ----
// Pin input stage: three flip-flops and an edge detector.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none
module tcs_pin_sync
  import tcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output tcs_pin_evt_s evt_out
);

  typedef struct packed {
    logic [TCS_SYNC_STAGES-1:0] sync;
    logic stable;
    tcs_pin_evt_s evt;
  } tcs_sync_state_s;

  tcs_sync_state_s st;
  tcs_sync_state_s next_st;

  // ==========================================================
  // Edge detection
  // A change counts once the second and third stages agree.
  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[TCS_SYNC_STAGES-2:0], pin_in};
    next_st.evt.rise = 1'b0;
    next_st.evt.fall = 1'b0;
    if (st.sync[1] == st.sync[2] && st.sync[2] != st.stable) begin
      next_st.stable = st.sync[2];
      next_st.evt.rise = st.sync[2];
      next_st.evt.fall = ~st.sync[2];
    end
    next_st.evt.level = next_st.stable;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt_out = st.evt;

endmodule
`default_nettype wire

// ---- design/tcs_channel.sv ----
// Status and control logic for one timer channel with its register port.
// Assumes the counter, modulo and channel value come from the counter core.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Capture mode: selected active pin edge sets the event flag.
// - Compare or PWM modes: counter equal to channel value sets the flag.
// - PWM at zero or full duty never sets the flag.
// - Channel request is high while flag and interrupt enable are both one.
// - Flag clears only after a read seeing it set, then writing zero.
// - An event during the clearing sequence keeps the flag set.
// - Reset clears the event flag and the interrupt enable.
// - Writing one to the flag does nothing; zero means no event.
// - Interrupt enable at bit 6 is read/write; one enables requests.
// - Without centre alignment, high mode bit selects edge-aligned PWM.
// - With both clear, low mode bit picks capture (0) or compare (1).
// - Pin changes just before capture mode may report a spurious edge.
// - Edge/level code 00 releases the pin whatever the mode.
// - Capture edge: 01 rising, 10 falling, 11 both.
// - Compare match: 01 toggles, 10 clears, 11 sets; 00 software only.
// - Centre PWM acts on match only counting up: 10 clears, X1 sets.
module tcs_channel
  import tcs_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic centre_aligned_select_in,
  input wire logic counting_up_in,
  input wire logic [CNT_W-1:0] counter_in,
  input wire logic [CNT_W-1:0] modulo_in,
  input wire logic [CNT_W-1:0] chan_value_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic chan_req_out,
  output logic irq_out
);

  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic mode_select_high;
    logic mode_select_low;
    logic edge_level_select_high;
    logic edge_level_select_low;
    logic armed;
    logic pin_q;
    logic [TCS_IRQ_W-1:0] irq_status;
    logic [TCS_IRQ_W-1:0] irq_mask;
    logic [7:0] rdata;
  } tcs_state_s;

  tcs_state_s st;
  tcs_state_s next_st;
  tcs_bus_req_s req;
  tcs_pin_evt_s pin_evt;
  tcs_mode_e mode;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] els;
  logic match;
  logic duty_extreme;
  logic capture_evt;
  logic match_evt;
  logic chan_evt;
  logic csc_wr;
  logic clearing_wr;
  logic [7:0] csc_view;

  // ==========================================================
  // Reset release
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Pin edges; a change close to a mode switch is still reported.
  tcs_pin_sync u_pin_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .pin_in(pin_in),
    .evt_out(pin_evt)
  );

  // ==========================================================
  // Mode decode and channel events
  always_comb begin
    if (centre_aligned_select_in) begin
      mode = TCS_MODE_CENTRE_PWM;
    end else if (st.mode_select_high) begin
      mode = TCS_MODE_EDGE_PWM;
    end else if (st.mode_select_low) begin
      mode = TCS_MODE_COMPARE;
    end else begin
      mode = TCS_MODE_CAPTURE;
    end
  end

  assign els = {st.edge_level_select_high, st.edge_level_select_low};
  assign match = (counter_in == chan_value_in);
  // Zero duty is a value of zero; full duty a value past the modulo.
  assign duty_extreme = (chan_value_in == '0) ||
      ((modulo_in != '0) && (chan_value_in > modulo_in));
  assign capture_evt = (mode == TCS_MODE_CAPTURE) &&
      ((st.edge_level_select_low && pin_evt.rise) ||
       (st.edge_level_select_high && pin_evt.fall));
  assign match_evt = (mode != TCS_MODE_CAPTURE) && match &&
      !(mode[1] && duty_extreme);
  assign chan_evt = capture_evt || match_evt;

  assign csc_wr = req.wr && (req.addr == TCS_ADDR_CSC);
  assign clearing_wr = csc_wr && st.armed &&
      !req.wdata[TCS_FLAG_BIT];
  assign csc_view = {st.channel_event_flag, st.channel_irq_enable,
      st.mode_select_high, st.mode_select_low,
      st.edge_level_select_high, st.edge_level_select_low, 2'h0};

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.rdata = TCS_RDATA_RESET;
    if (req.rd) begin
      case (req.addr)
        TCS_ADDR_CSC: begin
          next_st.rdata = csc_view;
          if (st.channel_event_flag) begin
            next_st.armed = 1'b1;
          end
        end
        TCS_ADDR_IRQ_STATUS: begin
          next_st.rdata = {6'h00, st.irq_status};
        end
        TCS_ADDR_IRQ_MASK: begin
          next_st.rdata = {6'h00, st.irq_mask};
        end
        default: begin
          next_st.rdata = TCS_RDATA_RESET;
        end
      endcase
    end
    if (csc_wr) begin
      next_st.channel_irq_enable = req.wdata[TCS_IE_BIT];
      next_st.mode_select_high = req.wdata[TCS_MSH_BIT];
      next_st.mode_select_low = req.wdata[TCS_MSL_BIT];
      next_st.edge_level_select_high = req.wdata[TCS_ELSH_BIT];
      next_st.edge_level_select_low = req.wdata[TCS_ELSL_BIT];
    end
    // Writing one leaves the flag alone; zero clears only when armed.
    if (clearing_wr) begin
      next_st.channel_event_flag = 1'b0;
      next_st.armed = 1'b0;
    end
    // A new event cancels an earlier read, so the next zero write keeps it.
    if (chan_evt) begin
      next_st.channel_event_flag = 1'b1;
      next_st.armed = 1'b0;
    end
    if (req.wr && req.addr == TCS_ADDR_IRQ_MASK) begin
      next_st.irq_mask = req.wdata[TCS_IRQ_W-1:0];
    end
    if (req.wr && req.addr == TCS_ADDR_IRQ_STATUS) begin
      next_st.irq_status = st.irq_status & ~req.wdata[TCS_IRQ_W-1:0];
    end
    // Sticky bits: setting wins over a clear in the same cycle.
    if (chan_evt) begin
      next_st.irq_status[TCS_IRQ_EVENT_BIT] = 1'b1;
      if (st.channel_event_flag) begin
        next_st.irq_status[TCS_IRQ_OVERRUN_BIT] = 1'b1;
      end
    end
    // Pin driver behaviour on a counter match, and at counter zero in edge PWM.
    case (mode)
      TCS_MODE_COMPARE: begin
        if (match) begin
          case (els)
            2'h1: next_st.pin_q = ~st.pin_q;
            2'h2: next_st.pin_q = 1'b0;
            2'h3: next_st.pin_q = 1'b1;
            default: next_st.pin_q = st.pin_q;
          endcase
        end
      end
      TCS_MODE_EDGE_PWM: begin
        if (match) begin
          next_st.pin_q = (els != TCS_ELS_CLEAR);
        end else if (counter_in == '0) begin
          next_st.pin_q = (els == TCS_ELS_CLEAR);
        end
      end
      TCS_MODE_CENTRE_PWM: begin
        if (match && counting_up_in) begin
          next_st.pin_q = (els != TCS_ELS_CLEAR);
        end
      end
      default: begin
        next_st.pin_q = st.pin_q;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out = st.rdata;
  assign pin_out = st.pin_q;
  assign pin_oe_out = (els != TCS_ELS_OFF) &&
      (mode != TCS_MODE_CAPTURE);
  assign chan_req_out = st.channel_event_flag &&
      st.channel_irq_enable;
  assign irq_out = |(st.irq_status & st.irq_mask);

  // ==========================================================
  // Assertions
  sequence s_read_flag_set;
    rd_in && addr_in == TCS_ADDR_CSC && st.channel_event_flag && !chan_evt;
  endsequence

  sequence s_clear_write;
    wr_in && addr_in == TCS_ADDR_CSC && !wdata_in[TCS_FLAG_BIT];
  endsequence

  property p_capture_sets;
    @(posedge clk_in) disable iff (!rst_n)
      capture_evt |=> st.channel_event_flag;
  endproperty
  a_capture_sets: assert property (p_capture_sets)
    else $error("capture edge did not set the flag");

  property p_match_sets;
    @(posedge clk_in) disable iff (!rst_n)
      (mode != TCS_MODE_CAPTURE) && match && !mode[1]
      |=> st.channel_event_flag;
  endproperty
  a_match_sets: assert property (p_match_sets)
    else $error("compare match did not set the flag");

  property p_duty_quiet;
    @(posedge clk_in) disable iff (!rst_n)
      mode[1] && duty_extreme && !st.channel_event_flag
      |=> !st.channel_event_flag;
  endproperty
  a_duty_quiet: assert property (p_duty_quiet)
    else $error("flag set at zero or full duty");

  property p_request;
    @(posedge clk_in) disable iff (!rst_n)
      chan_req_out == (csc_view[TCS_FLAG_BIT] && csc_view[TCS_IE_BIT]);
  endproperty
  a_request: assert property (p_request)
    else $error("channel request does not follow flag and enable");

  property p_clear_sequence;
    @(posedge clk_in) disable iff (!rst_n)
      $fell(st.channel_event_flag) |->
      $past(st.armed && wr_in && addr_in == TCS_ADDR_CSC &&
            !wdata_in[TCS_FLAG_BIT]);
  endproperty
  a_clear_sequence: assert property (p_clear_sequence)
    else $error("flag cleared without the read then write sequence");

  property p_read_then_clear;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_flag_set ##1 (s_clear_write and !chan_evt)
      |=> !st.channel_event_flag;
  endproperty
  a_read_then_clear: assert property (p_read_then_clear)
    else $error("read then zero write did not clear the flag");

  property p_set_wins;
    @(posedge clk_in) disable iff (!rst_n)
      s_clear_write and chan_evt |=> st.channel_event_flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost during the clearing sequence");

  property p_event_disarms;
    @(posedge clk_in) disable iff (!rst_n)
      chan_evt |=> !st.armed;
  endproperty
  a_event_disarms: assert property (p_event_disarms)
    else $error("event left the clearing sequence armed");

  property p_write_one;
    @(posedge clk_in) disable iff (!rst_n)
      csc_wr && req.wdata[TCS_FLAG_BIT] && st.channel_event_flag
      |=> st.channel_event_flag;
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("writing one changed the flag");

  property p_enable_write;
    @(posedge clk_in) disable iff (!rst_n)
      csc_wr |=> st.channel_irq_enable == $past(wdata_in[TCS_IE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("interrupt enable did not take the written value");

  property p_pin_release;
    @(posedge clk_in) disable iff (!rst_n)
      els == TCS_ELS_OFF |-> !pin_oe_out;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("pin driven with edge/level code zero");

endmodule
`default_nettype wire

// ---- tb/tcs_counter_model.sv ----
// Behavioural counter core that feeds the channel with count and direction.
// Assumes one clock shared with the channel and an active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tcs_counter_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic centre_in,
  input wire logic [15:0] modulo_in,
  output logic [15:0] counter_out,
  output logic counting_up_out
);
  // ==========================================================
  // Counter
  // Edge mode wraps to zero after the modulo; centre mode turns round.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      counter_out <= 16'h0000;
      counting_up_out <= 1'b1;
    end else if (!centre_in) begin
      counting_up_out <= 1'b1;
      counter_out <= (counter_out == modulo_in) ? 16'h0000 :
                     counter_out + 16'h0001;
    end else if (counting_up_out) begin
      counting_up_out <= (counter_out != modulo_in);
      counter_out <= (counter_out == modulo_in) ? counter_out - 16'h0001 :
                     counter_out + 16'h0001;
    end else begin
      counting_up_out <= (counter_out == 16'h0000);
      counter_out <= (counter_out == 16'h0000) ? 16'h0001 :
                     counter_out - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tcs_channel_tb.sv ----
// Self-checking bench for the timer channel status and control block.
// Assumes the counter model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none
module tcs_channel_tb
  import tcs_pkg::*;
;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic centre_in = 1'b0;
  logic pin_in = 1'b0;
  logic [15:0] cv_in = 16'h0010;
  logic [15:0] mod_in = 16'h0020;
  logic [15:0] cnt_w;
  logic up_w;
  logic [7:0] rdata_w;
  logic pin_w;
  logic oe_w;
  logic req_w;
  logic irq_w;
  logic [7:0] seen;
  logic p;
  int n_errors = 0;
  int check_count = 0;

  always #5 clk_in = ~clk_in;

  tcs_counter_model i_tcs_counter_model (.clk_in(clk_in), .rstn_in(rstn_in),
    .centre_in(centre_in), .modulo_in(mod_in), .counter_out(cnt_w),
    .counting_up_out(up_w));

  tcs_channel i_tcs_channel (.clk_in(clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_w), .centre_aligned_select_in(centre_in),
    .counting_up_in(up_w), .counter_in(cnt_w), .modulo_in(mod_in),
    .chan_value_in(cv_in), .pin_in(pin_in), .pin_out(pin_w),
    .pin_oe_out(oe_w), .chan_req_out(req_w), .irq_out(irq_w));

  // ==========================================================
  // Access and comparison tasks
  task automatic check(string name, logic [7:0] s, logic [7:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic chk1(string name, logic s, logic e);
    check(name, {7'h00, s}, {7'h00, e});
  endtask

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(string name, logic [3:0] a, logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    seen = rdata_w;
    check(name, seen, e);
  endtask

  // Clearing sequence: a read first, then zero written to the flag.
  task automatic clr_flag(logic [7:0] e);
    @(posedge clk_in);
    addr_in <= TCS_ADDR_CSC;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    wr_in <= 1'b1;
    wdata_in <= e & 8'h7f;
    #1;
    check("csc before clear", rdata_w, e);
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic wait_cnt(logic [15:0] v, logic up);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_in);
      #1;
      if (cnt_w == v && up_w == up) break;
    end
    chk1("counter reached", i < 200, 1'b1);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #300us;
    n_errors++;
    wrap_up();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd_chk("csc reset", TCS_ADDR_CSC, TCS_RDATA_RESET);
    rd_chk("mask reset", TCS_ADDR_IRQ_MASK, 8'h00);
    wr_reg(TCS_ADDR_CSC, 8'hc0);
    rd_chk("flag write one", TCS_ADDR_CSC, 8'h40);
    rd_chk("unmapped", 4'hc, 8'h00);
    for (int c = 1; c < 4; c++) begin
      wr_reg(TCS_ADDR_CSC, 8'h50 | 8'(c << 2));
      chk1("compare oe", oe_w, 1'b1);
      wait_cnt(16'h0010, 1'b1);
      p = pin_w;
      @(posedge clk_in);
      #1;
      chk1("compare pin", pin_w, (c == 1) ? ~p : c[1] & c[0]);
    end
    @(posedge clk_in);
    #1;
    chk1("request", req_w, 1'b1);
    rd_chk("status overrun", TCS_ADDR_IRQ_STATUS, 8'h03);
    @(posedge clk_in) cv_in <= 16'hffff;
    wr_reg(TCS_ADDR_CSC, 8'h5c);
    rd_chk("no read no clear", TCS_ADDR_CSC, 8'hdc);
    wr_reg(TCS_ADDR_CSC, 8'h5c);
    rd_chk("cleared", TCS_ADDR_CSC, 8'h5c);
    chk1("request off", req_w, 1'b0);
    @(posedge clk_in) cv_in <= 16'h0010;
    wait_cnt(16'h0010, 1'b1);
    rd_chk("armed", TCS_ADDR_CSC, 8'hdc);
    wait_cnt(16'h0010, 1'b1);
    @(posedge clk_in);
    wr_reg(TCS_ADDR_CSC, 8'h5c);
    rd_chk("event kept", TCS_ADDR_CSC, 8'hdc);
    wait_cnt(16'h000f, 1'b1);
    wr_reg(TCS_ADDR_CSC, 8'h5c);
    rd_chk("event beside clear", TCS_ADDR_CSC, 8'hdc);
    @(posedge clk_in) cv_in <= 16'hffff;
    clr_flag(8'hdc);
    rd_chk("cleared again", TCS_ADDR_CSC, 8'h5c);
    wr_reg(TCS_ADDR_IRQ_MASK, 8'h01);
    chk1("irq masked in", irq_w, 1'b1);
    wr_reg(TCS_ADDR_IRQ_MASK, 8'h00);
    chk1("irq masked out", irq_w, 1'b0);
    wr_reg(TCS_ADDR_IRQ_STATUS, 8'h03);
    rd_chk("status w1c", TCS_ADDR_IRQ_STATUS, 8'h00);
    wr_reg(TCS_ADDR_IRQ_MASK, 8'h03);
    chk1("irq none", irq_w, 1'b0);
    wr_reg(TCS_ADDR_CSC, 8'h50);
    chk1("released pin", oe_w, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr_reg(TCS_ADDR_CSC, 8'(c << 2));
      repeat (4) @(posedge clk_in);
      pin_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      clr_flag({c[0], 7'h00} | 8'(c << 2));
      repeat (4) @(posedge clk_in);
      pin_in <= 1'b0;
      repeat (8) @(posedge clk_in);
      clr_flag({c[1], 7'h00} | 8'(c << 2));
    end
    @(posedge clk_in) cv_in <= 16'h0000;
    wr_reg(TCS_ADDR_CSC, 8'h28);
    repeat (80) @(posedge clk_in);
    rd_chk("zero duty", TCS_ADDR_CSC, 8'h28);
    @(posedge clk_in) cv_in <= 16'h0021;
    repeat (80) @(posedge clk_in);
    rd_chk("full duty", TCS_ADDR_CSC, 8'h28);
    @(posedge clk_in) cv_in <= 16'h0010;
    wait_cnt(16'h0010, 1'b1);
    wait_cnt(16'h0012, 1'b1);
    chk1("edge pwm match", pin_w, 1'b0);
    wait_cnt(16'h0001, 1'b1);
    chk1("edge pwm start", pin_w, 1'b1);
    clr_flag(8'ha8);
    @(posedge clk_in) centre_in <= 1'b1;
    wr_reg(TCS_ADDR_CSC, 8'h08);
    wait_cnt(16'h0012, 1'b1);
    chk1("centre clear up", pin_w, 1'b0);
    wr_reg(TCS_ADDR_CSC, 8'h04);
    wait_cnt(16'h000e, 1'b0);
    chk1("centre down idle", pin_w, 1'b0);
    wait_cnt(16'h0012, 1'b1);
    chk1("centre set up", pin_w, 1'b1);
    chk1("centre oe", oe_w, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
